// *** eepc_ctrl.v ***
// byte program/erase controller for the nonvolatile array, APB slave
//
// Summary of operation
// - latch enable low forces erase and pump bits low; array reads like ROM
// - array reads while latch enable is set return all ones
// - erase uses only the written address; data value ignored
// - erased byte reads all ones, fully programmed byte reads all zeros
// - after an address is latched, further array writes are ignored
// - no other array access succeeds during erase or program
// - option byte copied into latches at every reset; storage unchanged
// - lowest 32 bytes unprotected; upper 224 need protect-off latch set
// - latched protection setting holds until the next reset
// - protect-off bit cleared only through a latched program sequence
// - readout lock zero refuses test mode; change acts after reset
// - self-check entry erases whole array, returning lock to one
// - STOP forces read mode and turns the pump off
// - WAIT does not disturb an operation or the pump
// - encodings 000 read, 010/011 program, 110/111 erase
// - pump settable only after address latched; cleared only with latch
// - erase select frozen once an address is latched
// - STOP and reset clear latch enable
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "eepc_regs.vh"

module eepc_ctrl #(
  parameter ERASE_CYC = `EEPC_ERASE_CYC,
  parameter PROG_CYC  = `EEPC_PROG_CYC
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // mode inputs
  input  wire        stop_mode_i,
  input  wire        self_check_i,
  input  wire        test_mode_req_i,
  // outputs
  output wire        test_mode_grant_o,
  output wire        pump_voltage_node_o,
  output wire        cpu_clock_out_select_o
);

  // ********************************************************
  // helper functions
  // ********************************************************
  function is_array;
    input [9:0] idx;
    begin
      is_array = (idx[9:8] == `EEPC_ARRAY_HI);
    end
  endfunction

  function is_upper;
    input [9:0] idx;
    begin
      is_upper = (idx[7:0] >= `EEPC_UPPER_FIRST);
    end
  endfunction

  function is_ctrl;
    input [9:0] idx;
    begin
      is_ctrl = (idx == `EEPC_CTRL_IDX);
    end
  endfunction

  function is_stat;
    input [9:0] idx;
    begin
      is_stat = (idx == `EEPC_STAT_IDX);
    end
  endfunction

  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = is_array(idx) ||
                  is_ctrl(idx)  ||
                  is_stat(idx);
    end
  endfunction

  // ********************************************************
  // declarations
  // ********************************************************
  // counts beyond the timer width would wrap; the defaults fit
  localparam integer           ERA_LAST_I = ERASE_CYC - 1;
  localparam integer           PRG_LAST_I = PROG_CYC - 1;
  localparam [`EEPC_TMR_W-1:0] ERA_LAST   =
    ERA_LAST_I[`EEPC_TMR_W-1:0];
  localparam [`EEPC_TMR_W-1:0] PRG_LAST   =
    PRG_LAST_I[`EEPC_TMR_W-1:0];

  reg                    pgm_q;
  reg                    lat_q;
  reg                    era_q;
  reg                    clko_q;
  reg                    addr_lat_q;
  reg  [7:0]             tgt_addr_q;
  reg  [7:0]             tgt_data_q;
  reg  [`EEPC_TMR_W-1:0] tmr_q;
  reg                    done_q;
  reg                    commit_q;
  reg                    era_cmt_q;
  reg                    opt_load_q;
  reg                    prot_off_q;
  reg                    lock_q;
  reg                    tsync1_q;
  reg                    tsync2_q;
  reg                    tsync3_q;
  reg                    tmode_q;
  reg                    grant_q;
  reg  [31:0]            prdata_q;
  reg                    pslverr_q;
  reg  [7:0]             rd_byte;

  wire [9:0]             idx;
  wire                   bad_addr;
  wire                   setup;
  wire                   acc;
  wire                   wr;
  wire                   wr_ctrl;
  wire                   wr_array;
  wire                   arr_ok;
  wire [7:0]             mem_rdata;
  wire [7:0]             mem_raddr;
  wire                   busy;
  wire [`EEPC_TMR_W-1:0] tmr_last;

  // ********************************************************
  // apb decode
  // ********************************************************
  assign idx      = paddr_i[11:2];
  assign bad_addr = (paddr_i[1:0] != 2'b00) || !is_mapped(idx);
  assign setup    = psel_i && !penable_i;
  assign acc      = psel_i && penable_i;
  assign pready_o = acc;
  assign wr       = acc && pwrite_i && pstrb_i[0] && !bad_addr;
  assign wr_ctrl  = wr && is_ctrl(idx);
  assign wr_array = wr && is_array(idx);

  // an address is taken only once per sequence and only where
  // the latched protection allows it
  assign arr_ok = lat_q && !addr_lat_q && !stop_mode_i &&
                  (!is_upper(idx) || prot_off_q);

  assign busy     = pgm_q && addr_lat_q && !done_q;
  assign tmr_last = era_q ? ERA_LAST : PRG_LAST;

  // ********************************************************
  // control register
  // ********************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pgm_q  <= 1'b0;
      lat_q  <= 1'b0;
      era_q  <= 1'b0;
      clko_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clko_q <= pwdata_i[`EEPC_CLKO_BIT];
      end
      if (stop_mode_i) begin
        // entering stop falls back to read mode, pump off
        lat_q <= 1'b0;
        era_q <= 1'b0;
        pgm_q <= 1'b0;
      end else if (wr_ctrl) begin
        if (!pwdata_i[`EEPC_LAT_BIT]) begin
          lat_q <= 1'b0;
          era_q <= 1'b0;
          pgm_q <= 1'b0;
        end else begin
          lat_q <= 1'b1;
          if (!addr_lat_q) begin
            era_q <= pwdata_i[`EEPC_ERA_BIT];
          end
          // sticky once set; only a latch clear drops it
          if (addr_lat_q && pwdata_i[`EEPC_PGM_BIT]) begin
            pgm_q <= 1'b1;
          end
        end
      end
    end
  end

  // ********************************************************
  // address and data latch
  // ********************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr_lat_q <= 1'b0;
      tgt_addr_q <= 8'h00;
      tgt_data_q <= 8'h00;
    end else if (!lat_q || stop_mode_i) begin
      addr_lat_q <= 1'b0;
    end else if (wr_array && arr_ok) begin
      addr_lat_q <= 1'b1;
      tgt_addr_q <= idx[7:0];
      // erase ignores this value at commit
      tgt_data_q <= pwdata_i[7:0];
    end
  end

  // ********************************************************
  // operation timer
  // ********************************************************
  // wait mode has no input here: the timer and pump keep
  // running on this clock while the cpu waits
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tmr_q    <= {`EEPC_TMR_W{1'b0}};
      done_q   <= 1'b0;
      commit_q  <= 1'b0;
      era_cmt_q <= 1'b0;
    end else if (!pgm_q || !addr_lat_q || stop_mode_i) begin
      // clearing the latch early abandons the byte untouched
      tmr_q    <= {`EEPC_TMR_W{1'b0}};
      done_q   <= 1'b0;
      commit_q <= 1'b0;
    end else if (!done_q) begin
      if (tmr_q == tmr_last) begin
        done_q    <= 1'b1;
        commit_q  <= 1'b1;
        // a latch clear on this edge also drops erase select, so
        // the commit keeps its own copy of it
        era_cmt_q <= era_q;
      end else begin
        tmr_q    <= tmr_q + {{(`EEPC_TMR_W-1){1'b0}}, 1'b1};
        commit_q <= 1'b0;
      end
    end else begin
      commit_q <= 1'b0;
    end
  end

  // ********************************************************
  // option byte latches
  // ********************************************************
  // copied one cycle after reset release; reset itself never
  // touches the stored byte, and later changes wait for reset
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      opt_load_q <= 1'b1;
      prot_off_q <= 1'b0;
      lock_q     <= 1'b0;
    end else begin
      opt_load_q <= 1'b0;
      if (opt_load_q) begin
        prot_off_q <= mem_rdata[`EEPC_PROT_BIT];
        lock_q     <= mem_rdata[`EEPC_LOCK_BIT];
      end
    end
  end

  assign mem_raddr = opt_load_q ? 8'h00 : idx[7:0];

  // ********************************************************
  // test mode request
  // ********************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tsync1_q <= 1'b0;
      tsync2_q <= 1'b0;
      tsync3_q <= 1'b0;
      tmode_q  <= 1'b0;
      grant_q  <= 1'b0;
    end else begin
      tsync1_q <= test_mode_req_i;
      tsync2_q <= tsync1_q;
      tsync3_q <= tsync2_q;
      if (tsync2_q == tsync3_q) begin
        tmode_q <= tsync3_q;
      end
      // lock bit at zero keeps the part out of test mode
      grant_q <= tmode_q && lock_q && !opt_load_q;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  always @* begin
    rd_byte = 8'h00;
    if (is_array(idx)) begin
      // array is unreadable whenever the latch is open
      rd_byte = lat_q ? `EEPC_BLANK_READ : mem_rdata;
    end else if (is_ctrl(idx)) begin
      rd_byte[`EEPC_PGM_BIT]  = pgm_q;
      rd_byte[`EEPC_LAT_BIT]  = lat_q;
      rd_byte[`EEPC_ERA_BIT]  = era_q;
      rd_byte[`EEPC_CLKO_BIT] = clko_q;
    end else if (is_stat(idx)) begin
      rd_byte[`EEPC_ST_ADDR_BIT] = addr_lat_q;
      rd_byte[`EEPC_ST_BUSY_BIT] = busy;
      rd_byte[`EEPC_ST_DONE_BIT] = done_q;
      rd_byte[`EEPC_ST_PROT_BIT] = prot_off_q;
      rd_byte[`EEPC_ST_LOCK_BIT] = lock_q;
    end
  end

  // data sampled in the setup cycle so the answer is a flop
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite_i ? 32'h0000_0000 :
                   (bad_addr ? 32'h0000_0000 : {24'h00_0000, rd_byte});
      pslverr_q <= bad_addr;
    end
  end

  assign prdata_o  = prdata_q;
  assign pslverr_o = acc && pslverr_q;

  // ********************************************************
  // array and outputs
  // ********************************************************
  eepc_array u_array (
    .clk_sys_i    (clk_sys_i),
    .raddr_i      (mem_raddr),
    .rdata_o      (mem_rdata),
    .commit_i     (commit_q),
    .erase_i      (era_cmt_q),
    .addr_i       (tgt_addr_q),
    .data_i       (tgt_data_q),
    .bulk_erase_i (self_check_i)
  );

  assign pump_voltage_node_o    = pgm_q && lat_q;
  assign cpu_clock_out_select_o = clko_q;
  assign test_mode_grant_o      = grant_q;

endmodule

// *** eepc_regs.vh ***
// register indices, field positions, reset values and timing counts
`ifndef EEPC_REGS_VH
`define EEPC_REGS_VH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define EEPC_CTRL_IDX       10'h007
`define EEPC_OPT_IDX        10'h100
`define EEPC_STAT_IDX       10'h030
`define EEPC_ARRAY_HI       2'b01
`define EEPC_UPPER_FIRST    8'h20

// ********************************************************
// control register fields
// ********************************************************
`define EEPC_PGM_BIT        0
`define EEPC_LAT_BIT        1
`define EEPC_ERA_BIT        2
`define EEPC_CLKO_BIT       3
`define EEPC_CTRL_RST       8'h00

// ********************************************************
// option byte fields
// ********************************************************
`define EEPC_LOCK_BIT       0
`define EEPC_PROT_BIT       1

// ********************************************************
// status register fields
// ********************************************************
`define EEPC_ST_ADDR_BIT    0
`define EEPC_ST_BUSY_BIT    1
`define EEPC_ST_DONE_BIT    2
`define EEPC_ST_PROT_BIT    3
`define EEPC_ST_LOCK_BIT    4

// ********************************************************
// data values
// ********************************************************
`define EEPC_ERASED         8'hff
`define EEPC_BLANK_READ     8'hff

// ********************************************************
// timing
// ********************************************************
`define EEPC_CLK_MHZ        100
`define EEPC_ERASE_TIME_US  10000
`define EEPC_PROG_TIME_US   10000
`define EEPC_ERASE_CYC      (`EEPC_ERASE_TIME_US * `EEPC_CLK_MHZ)
`define EEPC_PROG_CYC       (`EEPC_PROG_TIME_US * `EEPC_CLK_MHZ)
`define EEPC_TMR_W          24

`endif

// *** eepc_array.v ***
// 256-byte byte-erasable nonvolatile array with commit and bulk erase
`timescale 1ns/10ps
`include "eepc_regs.vh"

module eepc_array (
  // clock
  input  wire       clk_sys_i,
  // read port
  input  wire [7:0] raddr_i,
  output wire [7:0] rdata_o,
  // byte commit
  input  wire       commit_i,
  input  wire       erase_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] data_i,
  // whole-array erase
  input  wire       bulk_erase_i
);

  // contents survive reset: no reset term on purpose
  reg [7:0] mem [0:255];
  integer   k;

  assign rdata_o = mem[raddr_i];

  always @(posedge clk_sys_i) begin
    if (bulk_erase_i) begin
      for (k = 0; k < 256; k = k + 1) begin
        mem[k] <= `EEPC_ERASED;
      end
    end else if (commit_i) begin
      // programming can only pull bits low
      if (erase_i) begin
        mem[addr_i] <= `EEPC_ERASED;
      end else begin
        mem[addr_i] <= mem[addr_i] & data_i;
      end
    end
  end

endmodule

// *** eepc_checker.sv ***
// assertion checker for the nonvolatile program/erase controller
`timescale 1ns/10ps
module eepc_checker (
  // clock and reset
  input wire        clk_sys_i,
  input wire        rst_i,
  // apb
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0]  pstrb_i,
  input wire [31:0] prdata_o,
  input wire        pslverr_o,
  // modes and outputs
  input wire        stop_mode_i,
  input wire        test_mode_req_i,
  input wire        test_mode_grant_o,
  input wire        pump_voltage_node_o,
  input wire        cpu_clock_out_select_o
);
  // ********************************************************
  // latch mirror and assertions
  // ********************************************************
  wire acc = psel_i & penable_i;
  wire cwr = acc & pwrite_i & pstrb_i[0] & (paddr_i == 12'h01c);
  wire ard = acc & ~pwrite_i & (paddr_i[11:10] == 2'b01) &
             (paddr_i[1:0] == 2'b00);
  reg  lat_q;
  // stop wins over a write in the same cycle, as in the device
  always @(posedge clk_sys_i) begin
    if (rst_i | stop_mode_i)
      lat_q <= 1'b0;
    else if (cwr)
      lat_q <= pwdata_i[1];
  end
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_err_map;
    acc && paddr_i == 12'h020 |-> pslverr_o;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no error");
  property p_upper0;
    acc && !pwrite_i |-> prdata_o[31:8] == 24'h0;
  endproperty
  a_upper0: assert property (p_upper0) else $error("upper bits");
  // read data is taken in the setup cycle: compare with the latch then
  property p_ctrl_rd;
    acc && !pwrite_i && paddr_i == 12'h01c
      |-> prdata_o[7:4] == 4'h0 && ($past(lat_q) || prdata_o[2:0] == 3'h0);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl bits");
  property p_ff_rd;
    ard && $past(lat_q) |-> prdata_o[7:0] == 8'hff;
  endproperty
  a_ff_rd: assert property (p_ff_rd) else $error("array data");
  property p_pump_lat;
    pump_voltage_node_o |-> lat_q;
  endproperty
  a_pump_lat: assert property (p_pump_lat) else $error("pump on");
  property p_stop;
    stop_mode_i |=> !pump_voltage_node_o && !lat_q;
  endproperty
  a_stop: assert property (p_stop) else $error("pump in stop");
  property p_hold;
    pump_voltage_node_o && !stop_mode_i && !(cwr && !pwdata_i[1])
      |=> pump_voltage_node_o;
  endproperty
  a_hold: assert property (p_hold) else $error("pump dropped");
  property p_rise;
    $rose(pump_voltage_node_o) |-> $past(cwr);
  endproperty
  a_rise: assert property (p_rise) else $error("pump rose");
  property p_grant;
    !test_mode_req_i [*6] |=> !test_mode_grant_o;
  endproperty
  a_grant: assert property (p_grant) else $error("grant");
  property p_clko;
    cwr && !stop_mode_i |=> cpu_clock_out_select_o == $past(pwdata_i[3]);
  endproperty
  a_clko: assert property (p_clko) else $error("clock out");
endmodule
bind eepc_ctrl eepc_checker eepc_checker_inst (.clk_sys_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
  .pslverr_o, .stop_mode_i, .test_mode_req_i, .test_mode_grant_o,
  .pump_voltage_node_o, .cpu_clock_out_select_o);

// *** eepc_ctrl_tb_top.sv ***
// self-checking bench for the nonvolatile program/erase controller
`timescale 1ns/10ps
`include "eepc_regs.vh"
module eepc_ctrl_tb_top;
  // ********************************************************
  // signals, tasks and test sequence
  // ********************************************************
  localparam int          CYC  = 20;
  localparam logic [11:0] CTRL = {`EEPC_CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT = {`EEPC_STAT_IDX, 2'b00};
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h0;
  logic [31:0] pwdata    = 32'h0;
  logic        stop      = 1'b0;
  logic        selfchk   = 1'b0;
  logic        treq      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        grant;
  logic        pump;
  logic        clko;
  logic [7:0]  r;
  logic        e;
  int          mismatches = 0;
  int          checks     = 0;
  always #5 clk_sys_i = ~clk_sys_i; // pump rides this clock
  // short counts keep each byte commit to a few hundred ns
  eepc_ctrl #(.ERASE_CYC(CYC), .PROG_CYC(CYC)) eepc_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .stop_mode_i(stop),
    .self_check_i(selfchk), .test_mode_req_i(treq),
    .test_mode_grant_o(grant), .pump_voltage_node_o(pump),
    .cpu_clock_out_select_o(clko));
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        mismatches++;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    begin
      @(posedge clk_sys_i);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
        mismatches++;
        $display("Error %0t: no ready", $time);
        close_out();
      end
      r = prdata[7:0];
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    begin
      apb(1'b0, a, 8'h00);
      chk(r, x);
    end
  endtask
  function automatic logic [11:0] arr(input logic [7:0] i);
    return {`EEPC_ARRAY_HI, i, 2'b00};
  endfunction
  task automatic reset;
    begin
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
    end
  endtask
  // one whole byte sequence; the wait is the commit count plus margin
  // nothing else touches the array while it runs
  task automatic prog(input logic [7:0] i, input logic [7:0] d,
                      input logic era);
    begin
      wr(CTRL, {5'h0, era, 2'b10});
      wr(arr(i), d);
      wr(CTRL, {5'h0, era, 2'b11});
      repeat (CYC + 4) @(posedge clk_sys_i);
      wr(CTRL, 8'h00);
    end
  endtask
  initial begin
    reset();
    rd(CTRL, 8'h00);
    apb(1'b0, 12'h020, 8'h00);
    chk({7'h0, e}, 8'h01);
    @(posedge clk_sys_i);
    selfchk <= 1'b1;
    @(posedge clk_sys_i);
    selfchk <= 1'b0;
    reset();
    rd(STAT, 8'h18);
    rd(arr(8'h00), 8'hff);
    treq <= 1'b1;
    wr(CTRL, 8'h0d);
    rd(CTRL, 8'h08);
    chk({7'h0, clko}, 8'h01);
    chk({7'h0, pump}, 8'h00);
    chk({7'h0, grant}, 8'h01);
    $display("test reset and control done");
    wr(CTRL, 8'h02);
    wr(CTRL, 8'h03);
    rd(CTRL, 8'h02);
    wr(arr(8'h05), 8'ha5);
    wr(CTRL, 8'h07);
    rd(CTRL, 8'h03);
    chk({7'h0, pump}, 8'h01);
    wr(arr(8'h06), 8'h00);
    rd(arr(8'h05), 8'hff);
    repeat (CYC + 4) @(posedge clk_sys_i);
    rd(STAT, 8'h1d);
    wr(CTRL, 8'h00);
    rd(arr(8'h05), 8'ha5);
    rd(arr(8'h06), 8'hff);
    prog(8'h05, 8'h00, 1'b1);
    rd(arr(8'h05), 8'hff);
    prog(8'h05, 8'h00, 1'b0);
    rd(arr(8'h05), 8'h00);
    $display("test program and erase done");
    wr(CTRL, 8'h02);
    wr(arr(8'h07), 8'h00);
    wr(CTRL, 8'h03);
    @(posedge clk_sys_i);
    stop <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk({7'h0, pump}, 8'h00);
    stop <= 1'b0;
    rd(CTRL, 8'h00);
    rd(arr(8'h07), 8'hff);
    $display("test stop done");
    prog(8'h00, 8'hfc, 1'b0);
    prog(8'hf0, 8'h00, 1'b0);
    rd(arr(8'hf0), 8'h00);
    reset();
    rd(STAT, 8'h00);
    rd(arr(8'h00), 8'hfc);
    chk({7'h0, grant}, 8'h00);
    prog(8'hf1, 8'h00, 1'b0);
    rd(arr(8'hf1), 8'hff);
    prog(8'hf0, 8'h00, 1'b1);
    rd(arr(8'hf0), 8'h00);
    prog(8'h1f, 8'h00, 1'b0);
    rd(arr(8'h1f), 8'h00);
    $display("test protection done");
    close_out();
  end
endmodule
